// ===== logic/mem_order_unit.v
`timescale 1ns/1ns
`include "mem_order_defines.vh"

module mem_order_unit #(
   parameter EXT_SUPPORT = 1'b0,
   parameter ADD_EXPORT  = 1'b0
) (
   // clock and reset
   input  wire                clk_sys,
   input  wire                reset,
   input  wire                clk_en,
   // operation request
   input  wire                op_valid,
   output reg                 op_ready,
   input  wire [3:0]          op_kind,
   input  wire [1:0]          op_order,
   input  wire [2:0]          op_attr,
   input  wire                op_seq,
   input  wire                op_spec,
   input  wire                op_ext,
   input  wire                op_dep,
   input  wire                op_message,
   input  wire [`LINE_W-1:0]  op_line,
   // store buffer
   input  wire                sb_hit,
   input  wire                sb_empty,
   // memory side
   output reg                 mem_valid,
   input  wire                mem_ready,
   output reg  [3:0]          mem_kind,
   output reg  [`LINE_W-1:0]  mem_line,
   output reg                 mem_seq,
   output reg                 mem_total,
   output reg                 mem_coherent,
   output reg                 mem_bcast,
   output reg                 mem_export,
   output reg                 mem_forward,
   // visibility reports
   input  wire                vis_ack,
   input  wire                flush_ack,
   input  wire                sync_ack,
   // result
   output reg                 resp_valid,
   output reg  [1:0]          resp_fault,
   output reg                 resp_token,
   output reg                 resp_side_fx,
   output reg                 resp_dropped
);

   // ------------------------------
   // state and holding registers
   // ------------------------------
   localparam ST_IDLE  = 2'h0;
   localparam ST_CHECK = 2'h1;
   localparam ST_WAIT  = 2'h2;
   localparam ST_ISSUE = 2'h3;

   reg [1:0]          state;
   reg [3:0]          h_kind;
   reg [1:0]          h_order;
   reg [2:0]          h_attr;
   reg                h_seq;
   reg                h_spec;
   reg                h_ext;
   reg                h_dep;
   reg [`LINE_W-1:0]  h_line;
   reg [`CNT_W-1:0]   pend_vis;
   reg [`CNT_W-1:0]   pend_sync;
   reg                hold_after;
   reg                no_fwd;

   wire [1:0]         chk_fault;
   wire               chk_token;
   wire               chk_drop;
   wire               chk_export;
   wire               ft_hit;
   wire               ft_full;
   wire               ft_empty;
   wire               issue_fire;
   reg                can_issue;
   reg                next_forward;

   // saturating up/down counter step
   function [`CNT_W-1:0] count_step;
      input [`CNT_W-1:0] c;
      input              up;
      input              down;
      begin
         if (up && !down && c != `CNT_MAX)
            count_step = c + `CNT_ONE;
         else if (down && !up && c != `CNT_ZERO)
            count_step = c - `CNT_ONE;
         else
            count_step = c;
      end
   endfunction

   // kinds that read or write data memory
   function is_access;
      input [3:0] k;
      begin
         is_access = (k == `KIND_LOAD) || (k == `KIND_STORE) ||
                     (k == `KIND_SWAP) || (k == `KIND_ADD);
      end
   endfunction

   // ------------------------------
   // submodules
   // ------------------------------
   attr_fault_check #(
      .EXT_SUPPORT (EXT_SUPPORT),
      .ADD_EXPORT  (ADD_EXPORT)
   ) u_check (
      .kind       (h_kind),
      .attr       (h_attr),
      .spec       (h_spec),
      .ext        (h_ext),
      .fault      (chk_fault),
      .token      (chk_token),
      .drop       (chk_drop),
      .export_add (chk_export)
   );

   assign issue_fire = mem_valid && mem_ready;

   flush_line_table u_flush (
      .clk_sys   (clk_sys),
      .reset     (reset),
      .clk_en    (clk_en),
      .push      (issue_fire && mem_kind == `KIND_FLUSH),
      .push_line (mem_line),
      .pop       (flush_ack),
      .look_line (h_line),
      .hit       (ft_hit),
      .full      (ft_full),
      .empty     (ft_empty)
   );

   // ------------------------------
   // issue gate
   // ------------------------------
   // counters are conservative: one pool for every outstanding access,
   // which costs overlap but never breaks an ordering pair
   always @* begin
      can_issue = 1'b1;
      if (hold_after && pend_vis != `CNT_ZERO)
         can_issue = 1'b0;
      if ((h_order == `ORD_RELEASE || h_order == `ORD_FENCE ||
           h_kind == `KIND_FENCE) && pend_vis != `CNT_ZERO)
         can_issue = 1'b0;
      if (h_kind == `KIND_FENCE && pend_sync != `CNT_ZERO)
         can_issue = 1'b0;
      if (h_kind == `KIND_SYNC && !ft_empty)
         can_issue = 1'b0;
      if (h_dep && pend_vis != `CNT_ZERO)
         can_issue = 1'b0;
      if (h_kind == `KIND_FLUSH &&
          (pend_vis != `CNT_ZERO || ft_full))
         can_issue = 1'b0;
      if (is_access(h_kind) && ft_hit)
         can_issue = 1'b0;
   end

   // forwarding allowed only for plain loads once nothing blocks them
   always @* begin
      next_forward = 1'b0;
      if (h_kind == `KIND_LOAD && sb_hit && !no_fwd)
         next_forward = 1'b1;
   end

   // ------------------------------
   // sequencer
   // ------------------------------
   always @(posedge clk_sys) begin
      if (reset) begin
         state        <= ST_IDLE;
         op_ready     <= 1'b0;
         mem_valid    <= 1'b0;
         mem_kind     <= `KIND_LOAD;
         mem_line     <= {`LINE_W{1'b0}};
         mem_seq      <= 1'b0;
         mem_total    <= 1'b0;
         mem_coherent <= 1'b0;
         mem_bcast    <= 1'b0;
         mem_export   <= 1'b0;
         mem_forward  <= 1'b0;
         resp_valid   <= 1'b0;
         resp_fault   <= `FAULT_NONE;
         resp_token   <= 1'b0;
         resp_side_fx <= 1'b0;
         resp_dropped <= 1'b0;
         h_kind       <= `KIND_LOAD;
         h_order      <= `ORD_UNORDERED;
         h_attr       <= `ATTR_WB;
         h_seq        <= 1'b0;
         h_spec       <= 1'b0;
         h_ext        <= 1'b0;
         h_dep        <= 1'b0;
         h_line       <= {`LINE_W{1'b0}};
      end else if (clk_en) begin
         resp_valid <= 1'b0;
         case (state)
            ST_IDLE: begin
               op_ready <= 1'b1;
               if (op_valid && op_ready) begin
                  op_ready <= 1'b0;
                  h_kind   <= op_kind;
                  h_order  <= op_order;
                  h_attr   <= op_attr;
                  h_seq    <= op_seq && !op_message;
                  h_spec   <= op_spec;
                  h_ext    <= op_ext;
                  h_dep    <= op_dep;
                  h_line   <= op_line;
                  state    <= ST_CHECK;
               end
            end
            ST_CHECK: begin
               if (chk_fault != `FAULT_NONE || chk_token || chk_drop) begin
                  // no memory traffic for these outcomes
                  resp_valid   <= 1'b1;
                  resp_fault   <= chk_fault;
                  resp_token   <= chk_token;
                  resp_side_fx <= chk_token;
                  resp_dropped <= chk_drop;
                  state        <= ST_IDLE;
               end else
                  state <= ST_WAIT;
            end
            ST_WAIT: begin
               if (can_issue) begin
                  mem_valid    <= 1'b1;
                  mem_kind     <= h_kind;
                  mem_line     <= h_line;
                  mem_seq      <= h_seq;
                  mem_coherent <= (h_attr == `ATTR_WB);
                  mem_total    <= (h_attr == `ATTR_WB) &&
                                  ((h_kind == `KIND_STORE &&
                                    h_order == `ORD_RELEASE) ||
                                   h_kind == `KIND_SWAP ||
                                   h_kind == `KIND_ADD);
                  mem_bcast    <= (h_kind == `KIND_FLUSH);
                  mem_export   <= chk_export;
                  mem_forward  <= next_forward;
                  state        <= ST_ISSUE;
               end
            end
            ST_ISSUE: begin
               // single issue keeps sequential ops in program order
               if (issue_fire) begin
                  mem_valid    <= 1'b0;
                  resp_valid   <= 1'b1;
                  resp_fault   <= `FAULT_NONE;
                  resp_token   <= 1'b0;
                  resp_side_fx <= 1'b1;
                  resp_dropped <= 1'b0;
                  state        <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ------------------------------
   // visibility bookkeeping
   // ------------------------------
   // flushes are tracked apart, so a fence never waits on them; only a sync waits for the flush table to drain
   always @(posedge clk_sys) begin
      if (reset) begin
         pend_vis   <= `CNT_ZERO;
         pend_sync  <= `CNT_ZERO;
         hold_after <= 1'b0;
         no_fwd     <= 1'b0;
      end else if (clk_en) begin
         pend_vis  <= count_step(pend_vis,
                                 issue_fire && mem_kind != `KIND_FLUSH &&
                                 mem_kind != `KIND_SYNC,
                                 vis_ack);
         pend_sync <= count_step(pend_sync,
                                 issue_fire && mem_kind == `KIND_SYNC,
                                 sync_ack);
         if (issue_fire && (h_order == `ORD_ACQUIRE ||
                            h_order == `ORD_FENCE || h_kind == `KIND_FENCE))
            hold_after <= 1'b1;
         else if (pend_vis == `CNT_ZERO)
            hold_after <= 1'b0;
         // set wins over the drain-clear in the same cycle
         if (issue_fire && h_kind == `KIND_FENCE)
            no_fwd <= 1'b1;
         else if (sb_empty)
            no_fwd <= 1'b0;
      end
   end

endmodule // mem_order_unit

// ===== logic/mem_order_defines.vh
`ifndef MEM_ORDER_DEFINES_VH
`define MEM_ORDER_DEFINES_VH

// ------------------------------
// operation kinds
// ------------------------------
`define KIND_LOAD      4'h0
`define KIND_STORE     4'h1
`define KIND_SWAP      4'h2
`define KIND_ADD       4'h3
`define KIND_FLUSH     4'h4
`define KIND_SYNC      4'h5
`define KIND_FENCE     4'h6
`define KIND_PREFETCH  4'h7
`define KIND_FETCH     4'h8

// ------------------------------
// ordering classes
// ------------------------------
`define ORD_UNORDERED  2'h0
`define ORD_RELEASE    2'h1
`define ORD_ACQUIRE    2'h2
`define ORD_FENCE      2'h3

// ------------------------------
// memory attributes
// ------------------------------
`define ATTR_WB        3'h0
`define ATTR_WT        3'h1
`define ATTR_UC        3'h2
`define ATTR_UCE       3'h3
`define ATTR_WC        3'h4
`define ATTR_DEFERRED_TOKEN_PAGE   3'h5

// ------------------------------
// fault codes and sizes
// ------------------------------
`define FAULT_NONE     2'h0
`define FAULT_DEFERRED_TOKEN_PAGE  2'h1
`define FAULT_UNSUP    2'h2
`define LINE_W         26
`define CNT_W          4
`define CNT_MAX        4'hF
`define CNT_ONE        4'h1
`define CNT_ZERO       4'h0
`define FT_DEPTH       4
`define FT_IDX_W       2

`endif

// ===== logic/attr_fault_check.v
`timescale 1ns/1ns
`include "mem_order_defines.vh"

// attribute checks: pure decode, no state
module attr_fault_check #(
   parameter EXT_SUPPORT = 1'b0,
   parameter ADD_EXPORT  = 1'b0
) (
   // operation
   input  wire [3:0] kind,
   input  wire [2:0] attr,
   input  wire       spec,
   input  wire       ext,
   // verdict
   output reg  [1:0] fault,
   output reg        token,
   output reg        drop,
   output reg        export_add
);

   // write-back or write-through lines live in the caches
   function is_cacheable;
      input [2:0] a;
      begin
         is_cacheable = (a == `ATTR_WB) || (a == `ATTR_WT);
      end
   endfunction

   // ------------------------------
   // decode
   // ------------------------------
   always @* begin
      fault      = `FAULT_NONE;
      token      = 1'b0;
      drop       = 1'b0;
      export_add = 1'b0;
      case (kind)
         `KIND_LOAD: begin
            if (attr == `ATTR_DEFERRED_TOKEN_PAGE) begin
               if (spec)
                  token = 1'b1;
               else
                  fault = `FAULT_DEFERRED_TOKEN_PAGE;
            end else if (ext && attr != `ATTR_WB && !EXT_SUPPORT) begin
               if (spec)
                  token = 1'b1;
               else
                  fault = `FAULT_UNSUP;
            end
         end
         `KIND_STORE: begin
            if (attr == `ATTR_DEFERRED_TOKEN_PAGE)
               fault = `FAULT_DEFERRED_TOKEN_PAGE;
            else if (ext && attr != `ATTR_WB && !EXT_SUPPORT)
               fault = `FAULT_UNSUP;
         end
         `KIND_FETCH: begin
            if (attr == `ATTR_DEFERRED_TOKEN_PAGE)
               fault = `FAULT_DEFERRED_TOKEN_PAGE;
         end
         `KIND_SWAP: begin
            if (attr == `ATTR_DEFERRED_TOKEN_PAGE)
               fault = `FAULT_DEFERRED_TOKEN_PAGE;
            else if (attr != `ATTR_WB)
               fault = `FAULT_UNSUP;
         end
         `KIND_ADD: begin
            if (attr == `ATTR_DEFERRED_TOKEN_PAGE)
               fault = `FAULT_DEFERRED_TOKEN_PAGE;
            else if (attr == `ATTR_UCE) begin
               if (ADD_EXPORT)
                  export_add = 1'b1;
               else
                  fault = `FAULT_UNSUP;
            end else if (attr != `ATTR_WB)
               fault = `FAULT_UNSUP;
         end
         `KIND_PREFETCH: begin
            // silent: a prefetch never faults, it only goes away
            if (!is_cacheable(attr) || attr == `ATTR_DEFERRED_TOKEN_PAGE)
               drop = 1'b1;
         end
         default: begin
            // flush, sync and fence take no attribute fault
            fault = `FAULT_NONE;
         end
      endcase
   end

endmodule // attr_fault_check

// ===== logic/flush_line_table.v
`timescale 1ns/1ns
`include "mem_order_defines.vh"

// lines with a flush issued but not yet visible; acks come in issue order
module flush_line_table (
   // clock and control
   input  wire                 clk_sys,
   input  wire                 reset,
   input  wire                 clk_en,
   // updates
   input  wire                 push,
   input  wire [`LINE_W-1:0]   push_line,
   input  wire                 pop,
   // lookup
   input  wire [`LINE_W-1:0]   look_line,
   output reg                  hit,
   output wire                 full,
   output wire                 empty
);

   reg [`LINE_W-1:0]   line [0:`FT_DEPTH-1];
   reg [`FT_DEPTH-1:0] live;
   reg [`FT_IDX_W-1:0] wr_idx;
   reg [`FT_IDX_W-1:0] rd_idx;
   integer             i;

   assign full  = &live;
   assign empty = ~|live;

   // compare against every live entry
   always @* begin
      hit = 1'b0;
      for (i = 0; i < `FT_DEPTH; i = i + 1) begin
         if (live[i] && line[i] == look_line)
            hit = 1'b1;
      end
   end

   // ring of entries; a pop on an empty table is ignored
   always @(posedge clk_sys) begin
      if (reset) begin
         live   <= {`FT_DEPTH{1'b0}};
         wr_idx <= {`FT_IDX_W{1'b0}};
         rd_idx <= {`FT_IDX_W{1'b0}};
      end else if (clk_en) begin
         if (pop && live[rd_idx]) begin
            live[rd_idx] <= 1'b0;
            rd_idx       <= rd_idx + 1'b1;
         end
         if (push && !live[wr_idx]) begin
            live[wr_idx] <= 1'b1;
            line[wr_idx] <= push_line;
            wr_idx       <= wr_idx + 1'b1;
         end
      end
   end

endmodule // flush_line_table

// ===== tb/mem_side_model.sv
`timescale 1ns/1ns
`include "mem_order_defines.vh"
// ------------------------------
// far side: memory that accepts issues and acks them
// ------------------------------
module mem_side_model (
   // clock, reset, pacing
   input  logic       clk_sys,
   input  logic       reset,
   input  logic       slow,
   // memory handshake
   input  logic       mem_valid,
   input  logic [3:0] mem_kind,
   output logic       mem_ready,
   // visibility reports
   output logic       vis_ack,
   output logic       flush_ack,
   output logic       sync_ack
);
   logic [3:0] kinds[$];
   logic [3:0] head;
   int         wait_cnt;
   int         age;
   // stall then accept; visibility reported in issue order, at most one every second cycle
   always @(posedge clk_sys) begin
      vis_ack <= 1'b0;
      flush_ack <= 1'b0;
      sync_ack <= 1'b0;
      if (reset) begin
         mem_ready <= 1'b0;
         kinds.delete();
         wait_cnt <= 0;
         age <= 0;
      end else begin
         if (mem_valid && mem_ready) begin
            mem_ready <= 1'b0;
            kinds.push_back(mem_kind);
         end else if (mem_valid && wait_cnt == 0) begin
            mem_ready <= 1'b1;
         end else if (mem_valid) begin
            wait_cnt <= wait_cnt - 1;
         end else begin
            wait_cnt <= slow ? 3 : 0;
         end
         // slow acks let flushes pile up in the table
         if (kinds.size() > 0 && age >= (slow ? 12 : 1)) begin
            head = kinds.pop_front();
            flush_ack <= (head == `KIND_FLUSH);
            sync_ack <= (head == `KIND_SYNC);
            vis_ack <= (head != `KIND_FLUSH) && (head != `KIND_SYNC);
            age <= 0;
         end else begin
            age <= (kinds.size() > 0) ? age + 1 : 0;
         end
      end
   end
endmodule // mem_side_model

// ===== tb/mem_order_chk.sv
`timescale 1ns/1ns
`include "mem_order_defines.vh"
// ------------------------------
// port checker for the ordering unit
// ------------------------------
module mem_order_chk #(
   parameter EXT_SUPPORT = 1'b0
) (
   // clock, reset, request
   input logic       clk_sys, reset, clk_en, op_valid, op_ready, op_spec, op_ext,
   input logic [3:0] op_kind,
   input logic [1:0] op_order,
   input logic [2:0] op_attr,
   // memory side
   input logic       mem_valid, mem_ready, mem_total, mem_bcast, mem_forward,
   input logic [3:0] mem_kind,
   input logic       vis_ack, flush_ack,
   // result
   input logic       resp_valid, resp_token, resp_side_fx, resp_dropped,
   input logic [1:0] resp_fault
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   logic       take, hs, cur_strong, prev_strong;
   logic [3:0] pend, fl_pend;
   assign take = clk_en && op_valid && op_ready;
   assign hs = clk_en && mem_valid && mem_ready;
   // issued but not yet visible; strength of the last issued op
   always @(posedge clk_sys) begin
      if (reset) begin
         pend <= 4'h0;
         fl_pend <= 4'h0;
         cur_strong <= 1'b0;
         prev_strong <= 1'b0;
      end else begin
         if (take) cur_strong <= op_order[1] || (op_kind == `KIND_FENCE);
         if (hs) prev_strong <= cur_strong;
         pend <= pend + 4'(hs && mem_kind != `KIND_FLUSH && mem_kind != `KIND_SYNC)
                 - 4'(vis_ack);
         fl_pend <= fl_pend + 4'(hs && mem_kind == `KIND_FLUSH) - 4'(flush_ack);
      end
   end
   property p_strong_first;
      $rose(mem_valid) && prev_strong |-> pend == 4'h0;
   endproperty
   a_strong_first: assert property (p_strong_first)
      else $error("issued past unseen strong op");
   property p_sync_after_flush;
      $rose(mem_valid) && mem_kind == `KIND_SYNC |-> fl_pend == 4'h0;
   endproperty
   a_sync_after_flush: assert property (p_sync_after_flush)
      else $error("sync before flushes seen");
   property p_swap_fault;
      take && op_kind == `KIND_SWAP && op_attr != `ATTR_WB && op_attr != `ATTR_DEFERRED_TOKEN_PAGE
      |-> ##2 resp_valid && resp_fault == `FAULT_UNSUP;
   endproperty
   a_swap_fault: assert property (p_swap_fault)
      else $error("swap not refused");
   property p_add_fault;
      take && op_kind == `KIND_ADD && op_attr inside {`ATTR_WT, `ATTR_UC, `ATTR_WC}
      |-> ##2 resp_valid && resp_fault == `FAULT_UNSUP;
   endproperty
   a_add_fault: assert property (p_add_fault)
      else $error("add not refused");
   property p_nat_fault;
      take && op_attr == `ATTR_DEFERRED_TOKEN_PAGE && !op_spec && op_kind inside {`KIND_LOAD,
      `KIND_STORE, `KIND_SWAP, `KIND_ADD, `KIND_FETCH}
      |-> ##2 resp_valid && resp_fault == `FAULT_DEFERRED_TOKEN_PAGE && !resp_token;
   endproperty
   a_nat_fault: assert property (p_nat_fault)
      else $error("token page not faulted");
   property p_nat_token;
      take && op_kind == `KIND_LOAD && op_spec && op_attr == `ATTR_DEFERRED_TOKEN_PAGE
      |-> ##2 resp_valid && resp_token && resp_side_fx && resp_fault == `FAULT_NONE;
   endproperty
   a_nat_token: assert property (p_nat_token)
      else $error("no token");
   property p_ext_fault;
      take && !EXT_SUPPORT && op_ext && !op_spec && op_kind inside {`KIND_LOAD, `KIND_STORE}
      && op_attr inside {`ATTR_WT, `ATTR_UC, `ATTR_UCE, `ATTR_WC}
      |-> ##2 resp_valid && resp_fault == `FAULT_UNSUP;
   endproperty
   a_ext_fault: assert property (p_ext_fault)
      else $error("extended not refused");
   property p_ext_defer;
      take && !EXT_SUPPORT && op_ext && op_spec && op_kind == `KIND_LOAD
      && op_attr inside {`ATTR_WT, `ATTR_UC, `ATTR_UCE, `ATTR_WC}
      |-> ##2 resp_valid && resp_token && resp_fault == `FAULT_NONE;
   endproperty
   a_ext_defer: assert property (p_ext_defer)
      else $error("extended not deferred");
   property p_prefetch_drop;
      take && op_kind == `KIND_PREFETCH && op_attr inside {`ATTR_UC, `ATTR_UCE, `ATTR_WC}
      |-> (!mem_valid)[*3] and (##2 resp_valid && resp_dropped && resp_fault == 2'h0);
   endproperty
   a_prefetch_drop: assert property (p_prefetch_drop)
      else $error("prefetch not dropped");
   property p_flush_bcast;
      mem_valid && mem_kind == `KIND_FLUSH |-> mem_bcast;
   endproperty
   a_flush_bcast: assert property (p_flush_bcast)
      else $error("flush not broadcast");
   property p_sema_direct;
      mem_valid && mem_kind == `KIND_SWAP |-> !mem_forward && mem_total;
   endproperty
   a_sema_direct: assert property (p_sema_direct)
      else $error("swap forwarded or unordered");
   // main scenarios reached
   c_flush: cover property (take && op_kind == `KIND_FLUSH);
   c_sync: cover property ($rose(mem_valid) && mem_kind == `KIND_SYNC);
   c_strong: cover property ($rose(mem_valid) && prev_strong);
endmodule // mem_order_chk
bind mem_order_unit mem_order_chk #(.EXT_SUPPORT(EXT_SUPPORT)) u_chk (.clk_sys, .reset,
   .clk_en, .op_valid, .op_ready, .op_spec, .op_ext, .op_kind, .op_order, .op_attr,
   .mem_valid, .mem_ready, .mem_total, .mem_bcast, .mem_forward, .mem_kind, .vis_ack,
   .flush_ack, .resp_valid, .resp_token, .resp_side_fx, .resp_dropped, .resp_fault);

// ===== tb/memory_ordering_attribute_unit_tb.sv
`timescale 1ns/1ns
`include "mem_order_defines.vh"
// ------------------------------
// self-checking bench for the ordering unit
// ------------------------------
module memory_ordering_attribute_unit_tb;
   localparam EXT_SUPPORT = 1'b0;
   localparam ADD_EXPORT  = 1'b0;
   logic clk_sys = 1'b0, reset = 1'b1, clk_en = 1'b1, slow = 1'b0, op_valid = 1'b0;
   logic op_seq = 1'b0, op_spec = 1'b0, op_ext = 1'b0, op_dep = 1'b0, op_message = 1'b0;
   logic sb_hit = 1'b0, sb_empty = 1'b1;
   logic [3:0] op_kind = 4'h0;
   logic [1:0] op_order = 2'h0;
   logic [2:0] op_attr = 3'h0;
   logic [`LINE_W-1:0] op_line = 26'h0, mem_line;
   logic op_ready, mem_valid, mem_ready, mem_seq, mem_total, mem_coherent, mem_bcast;
   logic mem_export, mem_forward, vis_ack, flush_ack, sync_ack, resp_valid;
   logic resp_token, resp_side_fx, resp_dropped;
   logic [3:0] mem_kind;
   logic [1:0] resp_fault;
   logic [34:0] cap;
   int issues = 0, comparisons = 0, mismatches = 0;
   always #10 clk_sys = ~clk_sys;
   mem_order_unit #(.EXT_SUPPORT(EXT_SUPPORT), .ADD_EXPORT(ADD_EXPORT)) u_dut (.clk_sys,
      .reset, .clk_en, .op_valid, .op_ready, .op_kind, .op_order, .op_attr, .op_seq,
      .op_spec, .op_ext, .op_dep, .op_message, .op_line, .sb_hit, .sb_empty, .mem_valid,
      .mem_ready, .mem_kind, .mem_line, .mem_seq, .mem_total, .mem_coherent, .mem_bcast,
      .mem_export, .mem_forward, .vis_ack, .flush_ack, .sync_ack, .resp_valid,
      .resp_fault, .resp_token, .resp_side_fx, .resp_dropped);
   mem_side_model u_far (.clk_sys, .reset, .slow, .mem_valid, .mem_kind, .mem_ready,
      .vis_ack, .flush_ack, .sync_ack);
   // last issue as the far side accepted it
   always @(posedge clk_sys) if (mem_valid && mem_ready) begin
      cap <= {mem_kind, mem_line, mem_seq, mem_total, mem_bcast, mem_coherent, mem_export};
      issues <= issues + 1;
   end
   // verdict, also reached when a wait runs out
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [39:0] got, input logic [39:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL at %0t: seen %h expected %h", $time, got, exp);
      end
   endtask
   // reference: {fault, token, dropped, issued}
   function automatic logic [4:0] model(input logic [3:0] k, input logic [2:0] a,
                                        input logic s, input logic x);
      logic wb, deferred_exception_token;
      wb = (a == `ATTR_WB);
      deferred_exception_token = (a == `ATTR_DEFERRED_TOKEN_PAGE);
      if (k == `KIND_PREFETCH) model = (a > `ATTR_WT) ? 5'h02 : 5'h01;
      else if (k == `KIND_LOAD && s && deferred_exception_token) model = 5'h04;
      else if (deferred_exception_token && (k <= `KIND_ADD || k == `KIND_FETCH)) model = 5'h08;
      else if (k == `KIND_SWAP && !wb) model = 5'h10;
      else if (k == `KIND_ADD && !wb && !(a == `ATTR_UCE && ADD_EXPORT)) model = 5'h10;
      else if (k <= `KIND_STORE && x && !wb && !EXT_SUPPORT) model = s ? 5'h04 : 5'h10;
      else model = 5'h01;
   endfunction
   // one request, held until taken, then its result compared
   task automatic do_op(input logic [3:0] k, input logic [1:0] o, input logic [2:0] a,
                        input logic s, input logic x, input logic [25:0] ln);
      logic [4:0] e;
      logic [34:0] c;
      int n, base;
      e = model(k, a, s, x);
      base = issues;
      n = 0;
      {op_kind, op_order, op_attr, op_spec, op_ext, op_line} <= {k, o, a, s, x, ln};
      {op_seq, op_dep, op_message, sb_hit, sb_empty} <= 5'($urandom);
      op_valid <= 1'b1;
      do begin @(negedge clk_sys); n++; end while (op_ready !== 1'b1 && n < 300);
      @(posedge clk_sys);
      op_valid <= 1'b0;
      do begin @(negedge clk_sys); n++; end while (resp_valid !== 1'b1 && n < 600);
      if (resp_valid !== 1'b1) begin
         mismatches++;
         tally_and_finish();
      end
      c = {k, ln, op_seq && !op_message, a == `ATTR_WB && (k == `KIND_SWAP || k == `KIND_ADD
           || (k == `KIND_STORE && o == `ORD_RELEASE)), k == `KIND_FLUSH, a == `ATTR_WB,
           ADD_EXPORT && k == `KIND_ADD && a == `ATTR_UCE};
      check(40'(resp_fault), 40'(e[4:3]));
      check(40'(resp_token), 40'(e[2]));
      check(40'(resp_dropped), 40'(e[1]));
      check(40'(resp_side_fx), 40'(e[2] | e[0]));
      if (k <= `KIND_FLUSH) check(40'(issues != base), 40'(e[0]));
      if (k <= `KIND_FLUSH && e[0]) check(40'(cap), 40'(c));
      @(posedge clk_sys);
   endtask
   initial begin
      logic [3:0] k;
      void'($urandom(28451));
      repeat (4) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      // every kind against every attribute and order; spec variants on loads only, ext on loads and stores
      for (int i = 0; i < 216; i++)
         do_op(4'(i / 24), 2'(i), 3'((i / 4) % 6), i < 24 && i[0], i < 48 && i[1],
               26'(i % 6));
      // flush burst against a slow far side, then sync, fence, same-line load
      slow <= 1'b1;
      for (int i = 0; i < 5; i++) do_op(`KIND_FLUSH, 2'h0, `ATTR_UC, 1'b0, 1'b0, 26'(i));
      do_op(`KIND_SYNC, 2'h0, `ATTR_WB, 1'b0, 1'b0, 26'h0);
      do_op(`KIND_FENCE, `ORD_FENCE, `ATTR_WB, 1'b0, 1'b0, 26'h0);
      do_op(`KIND_LOAD, `ORD_ACQUIRE, `ATTR_WB, 1'b0, 1'b0, 26'h4);
      // reset in mid-run
      reset <= 1'b1;
      repeat (4) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      repeat (300) begin
         slow <= 1'($urandom);
         k = 4'($urandom % 9);
         do_op(k, 2'($urandom), 3'($urandom % 6), k == 0 && 1'($urandom),
               k < 2 && 1'($urandom), 26'($urandom % 4));
      end
      tally_and_finish();
   end
endmodule // memory_ordering_attribute_unit_tb
